// [shared/ada_pkg.sv]
// Shared constants and types for the bus address decoder
package ada_pkg;
	localparam int ADDR_W = 10;
	localparam int CFG_W = 12;
	localparam int EVT_W = 15;
	localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
	localparam logic [4:0] TEN_PREFIX = 5'h1e;
	localparam logic [4:0] EXT_PREFIX = 5'h1f;
	localparam logic [4:0] HS_PREFIX = 5'h01;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [6:0] OTHER_BUS_ADDR = 7'h01;
	localparam logic [6:0] FOREIGN_ADDR = 7'h02;
	localparam logic [6:0] FUTURE_ADDR = 7'h03;
	localparam logic [7:0] GC_CMD_RESET = 8'h06;
	localparam logic [7:0] GC_CMD_LOAD = 8'h04;
	localparam logic [7:0] SYNC_BYTE = 8'h01;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR = 3'b001,
		ST_LOW = 3'b010,
		ST_GC = 3'b011,
		ST_HWM = 3'b100,
		ST_RX = 3'b101,
		ST_TX = 3'b110,
		ST_SKIP = 3'b111
	} ada_state_t;
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_RESET = 2'b01,
		EV_LOAD = 2'b10,
		EV_HWM = 2'b11
	} ada_event_t;
endpackage

// [shared/ada_xfer_if.sv]
// Word crossing carrier between two clock domains
`timescale 1ns/1ps
interface ada_xfer_if #(parameter int W = 8);
	logic [W-1:0] s_data;
	logic s_load;
	logic s_busy;
	logic [W-1:0] d_data;
	logic d_valid;
	modport src (output s_data, output s_load, input s_busy);
	modport dst (input d_data, input d_valid);
	modport core (input s_data, input s_load, output s_busy, output d_data, output d_valid);
endinterface

// [core/ada_cdc.sv]
// Handshake word crossing with toggle request and toggle acknowledge
`timescale 1ns/1ps
module ada_cdc #(
	parameter int W = 8
) (
	input wire logic src_clk_i,
	input wire logic dst_clk_i,
	input wire logic nrst_i,
	ada_xfer_if.core x
);
	logic [W-1:0] hold_q;
	logic req_q;
	logic [2:0] ack_s_q;
	logic ack_seen_q;
	logic [2:0] req_s_q;
	logic ack_q;
	logic [W-1:0] data_q;
	logic valid_q;
	// Hold stays frozen until the far side acknowledges, so the word is stable when sampled
	assign x.s_busy = req_q != ack_seen_q;
	assign x.d_data = data_q;
	assign x.d_valid = valid_q;
	always_ff @(posedge src_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_q <= '0;
			req_q <= 1'b0;
			ack_s_q <= 3'b000;
			ack_seen_q <= 1'b0;
		end else begin
			ack_s_q <= {ack_s_q[1:0], ack_q};
			if (ack_s_q[1] == ack_s_q[2])
				ack_seen_q <= ack_s_q[2];
			if (x.s_load && !x.s_busy) begin
				hold_q <= x.s_data;
				req_q <= ~req_q;
			end
		end
	end
	always_ff @(posedge dst_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_s_q <= 3'b000;
			ack_q <= 1'b0;
			data_q <= '0;
			valid_q <= 1'b0;
		end else begin
			req_s_q <= {req_s_q[1:0], req_q};
			valid_q <= 1'b0;
			if (req_s_q[1] == req_s_q[2] && req_s_q[2] != ack_q) begin
				data_q <= hold_q;
				ack_q <= req_s_q[2];
				valid_q <= 1'b1;
			end
		end
	end
endmodule

// [core/ada_addr_decoder.sv]
// Slave address recognition for the two-wire bus, link logic on its own sampling clock
// Behaviour
// - A 10-bit header is prefix 11110, two high address bits, then direction bit.
// - Headers 11111xx are never taken as 10-bit addressing.
// - After START, 10-bit slave acks a write header matching its prefix and high bits.
// - Header-matched 10-bit slave acks second byte only on exact low-bit match.
// - Addressed 10-bit slave stays selected until STOP or restart with another address.
// - Remembered selection plus matching read header after restart: ack and become transmitter.
// - Unselected 10-bit slave ignores read header; 7-bit slave never matches 11110xx.
// - Broadcast handled as for 7-bit; announced 10-bit master low bits follow.
// - Address 0000000 with write direction is the broadcast address.
// - Address 0000000 with read direction is the sync byte; never acknowledged.
// - Address 0000001 belongs to another bus; never acknowledged.
// - Address 0000010 is for foreign formats; unsupported here, so never acknowledged.
// - 0000011, 00001xx and 11111xx with read are reserved, not slave addresses.
// - Broadcast acked only when its content is wanted, then act as receiver.
// - Later broadcast bytes are acked only when they can be handled.
// - Second broadcast byte bit zero: 0 is command set, 1 is master announcement.
// - Broadcast command 06h resets and loads the programmable address part.
// - Broadcast command 04h loads the programmable address part without reset.
// - Other even second broadcast bytes are ignored and not acknowledged.
// - Announcement upper seven bits carry the hardware master address, captured here.
// - Every START or repeated START rearms the logic to expect an address.
// - Direction bit zero is master write, one is master read.
`timescale 1ns/1ps
module ada_addr_decoder (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [9:0] own_addr_i,
	input wire logic ten_bit_i,
	input wire logic gc_en_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic addressed_o,
	output logic transmitter_o,
	output logic gc_reset_o,
	output logic gc_load_o,
	output logic hw_master_o,
	output logic hw_master_ten_o,
	output logic [9:0] hw_master_addr_o
);
	ada_xfer_if #(.W(ada_pkg::CFG_W)) cfg_x ();
	ada_xfer_if #(.W(ada_pkg::EVT_W)) evt_x ();

	ada_cdc #(.W(ada_pkg::CFG_W)) u_cfg_cdc (
		.src_clk_i(clk_i),
		.dst_clk_i(link_clk_i),
		.nrst_i(nrst_i),
		.x(cfg_x)
	);
	ada_cdc #(.W(ada_pkg::EVT_W)) u_evt_cdc (
		.src_clk_i(link_clk_i),
		.dst_clk_i(clk_i),
		.nrst_i(nrst_i),
		.x(evt_x)
	);

	// System side: configuration source
	logic [ada_pkg::CFG_W-1:0] cfg_sent_q;
	wire [ada_pkg::CFG_W-1:0] cfg_now = {ten_bit_i, gc_en_i, own_addr_i};
	assign cfg_x.s_data = cfg_now;
	assign cfg_x.s_load = cfg_now != cfg_sent_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			cfg_sent_q <= ada_pkg::CFG_RST;
		else if (cfg_x.s_load && !cfg_x.s_busy)
			cfg_sent_q <= cfg_now;
	end

	// Link side: configuration copy
	logic [ada_pkg::CFG_W-1:0] cfg_q;
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			cfg_q <= ada_pkg::CFG_RST;
		else if (cfg_x.d_valid)
			cfg_q <= cfg_x.d_data;
	end
	wire ten_l = cfg_q[11];
	wire gc_en_l = cfg_q[10];
	wire [9:0] own_l = cfg_q[9:0];

	// Pin sampling: a level counts once the second and third stages agree
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] pin_s3_q;
	logic [1:0] filt_q;
	logic [1:0] prev_q;
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1_q <= 2'b11;
			pin_s2_q <= 2'b11;
			pin_s3_q <= 2'b11;
			filt_q <= 2'b11;
			prev_q <= 2'b11;
		end else begin
			pin_s1_q <= {scl_i, sda_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int i = 0; i < 2; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i])
					filt_q[i] <= pin_s3_q[i];
			end
			prev_q <= filt_q;
		end
	end
	wire scl_f = filt_q[1];
	wire sda_f = filt_q[0];
	wire scl_p = prev_q[1];
	wire sda_p = prev_q[0];
	wire start_w = scl_f && scl_p && sda_p && !sda_f;
	wire stop_w = scl_f && scl_p && !sda_p && sda_f;
	wire rise_w = scl_f && !scl_p;
	wire fall_w = !scl_f && scl_p;

	ada_pkg::ada_state_t state_q;
	ada_pkg::ada_state_t dec_st;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic sel10_q;
	logic ack_q;
	logic sda_q;
	logic [6:0] hwm_q;

	wire byte_done = fall_w && bit_q == ada_pkg::BIT_LAST;
	wire ack_end = fall_w && bit_q == ada_pkg::ACK_SLOT;
	wire [6:0] a7 = shift_q[7:1];
	wire rw = shift_q[0];

	// Address class decoding
	wire is_ten_hdr = a7[6:2] == ada_pkg::TEN_PREFIX;
	wire is_ext = a7[6:2] == ada_pkg::EXT_PREFIX;
	wire hi_match = a7[1:0] == own_l[9:8];
	wire is_gc = a7 == ada_pkg::GC_ADDR && rw == ada_pkg::RW_WRITE;
	wire is_sync = a7 == ada_pkg::GC_ADDR && rw == ada_pkg::RW_READ;
	wire is_rsv = a7 == ada_pkg::OTHER_BUS_ADDR || a7 == ada_pkg::FOREIGN_ADDR || a7 == ada_pkg::FUTURE_ADDR
		|| a7[6:2] == ada_pkg::HS_PREFIX;
	wire header_ack = ten_l && is_ten_hdr && hi_match && rw == ada_pkg::RW_WRITE;
	wire readdress_ack = ten_l && is_ten_hdr && hi_match && rw == ada_pkg::RW_READ && sel10_q;
	wire seven_ack = !ten_l && !is_ten_hdr && !is_ext && !is_rsv && a7 != ada_pkg::GC_ADDR
		&& a7 == own_l[6:0];
	wire gc_ack = gc_en_l && is_gc;
	wire low_address_ack = shift_q == own_l[7:0];
	wire hwm_ten = hwm_q[6:2] == ada_pkg::TEN_PREFIX;

	logic dec_ack;
	logic dec_sel;
	ada_pkg::ada_event_t dec_ev;
	always_comb begin
		dec_st = ada_pkg::ST_SKIP;
		dec_ack = 1'b0;
		dec_sel = sel10_q;
		dec_ev = ada_pkg::EV_NONE;
		unique case (state_q)
			ada_pkg::ST_HDR: begin
				// Any new header ends an earlier 10-bit selection unless it re-addresses us
				dec_sel = 1'b0;
				if (header_ack) begin
					dec_ack = 1'b1;
					dec_st = ada_pkg::ST_LOW;
				end else if (readdress_ack) begin
					dec_ack = 1'b1;
					dec_sel = 1'b1;
					dec_st = ada_pkg::ST_TX;
				end else if (seven_ack) begin
					dec_ack = 1'b1;
					dec_st = rw ? ada_pkg::ST_TX : ada_pkg::ST_RX;
				end else if (gc_ack) begin
					dec_ack = 1'b1;
					dec_st = ada_pkg::ST_GC;
				end
			end
			ada_pkg::ST_LOW: begin
				if (low_address_ack) begin
					dec_ack = 1'b1;
					dec_sel = 1'b1;
					dec_st = ada_pkg::ST_RX;
				end
			end
			ada_pkg::ST_GC: begin
				if (shift_q[0]) begin
					dec_ack = 1'b1;
					dec_st = ada_pkg::ST_HWM;
				end else if (shift_q == ada_pkg::GC_CMD_RESET) begin
					dec_ack = 1'b1;
					dec_ev = ada_pkg::EV_RESET;
					dec_st = ada_pkg::ST_RX;
				end else if (shift_q == ada_pkg::GC_CMD_LOAD) begin
					dec_ack = 1'b1;
					dec_ev = ada_pkg::EV_LOAD;
					dec_st = ada_pkg::ST_RX;
				end
				// Code 00h and undefined even codes fall through unacknowledged
			end
			ada_pkg::ST_HWM: begin
				dec_ack = 1'b1;
				dec_ev = ada_pkg::EV_HWM;
				dec_st = ada_pkg::ST_RX;
			end
			ada_pkg::ST_RX: begin
				dec_ack = 1'b1;
				dec_st = ada_pkg::ST_RX;
			end
			ada_pkg::ST_TX: dec_st = ada_pkg::ST_TX;
			ada_pkg::ST_IDLE: dec_st = ada_pkg::ST_IDLE;
			ada_pkg::ST_SKIP: dec_st = ada_pkg::ST_SKIP;
		endcase
	end

	// Byte framing and acknowledge drive
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ada_pkg::ST_IDLE;
			bit_q <= ada_pkg::BIT_FIRST;
			shift_q <= 8'h00;
			sel10_q <= 1'b0;
			ack_q <= 1'b0;
			hwm_q <= 7'h00;
		end else if (start_w) begin
			// Also discards a sync byte: the following restart rearms us
			state_q <= ada_pkg::ST_HDR;
			bit_q <= ada_pkg::BIT_FIRST;
			ack_q <= 1'b0;
		end else if (stop_w) begin
			state_q <= ada_pkg::ST_IDLE;
			bit_q <= ada_pkg::BIT_FIRST;
			sel10_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			if (rise_w && bit_q < ada_pkg::BIT_LAST && state_q != ada_pkg::ST_IDLE) begin
				shift_q <= {shift_q[6:0], sda_f};
				bit_q <= bit_q + 4'h1;
			end
			if (byte_done) begin
				bit_q <= ada_pkg::ACK_SLOT;
				ack_q <= dec_ack;
				state_q <= dec_st;
				sel10_q <= dec_sel;
				if (state_q == ada_pkg::ST_GC)
					hwm_q <= shift_q[7:1];
			end
			if (ack_end) begin
				bit_q <= ada_pkg::BIT_FIRST;
				ack_q <= 1'b0;
			end
		end
	end

	// Open-drain data pin: only ever pulls low
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			sda_q <= 1'b0;
		else
			sda_q <= 1'b0;
	end
	assign sda_o = sda_q;
	assign sda_oe_o = ack_q;

	// Link side: status and event source
	wire [1:0] stat_now = {state_q == ada_pkg::ST_RX || state_q == ada_pkg::ST_TX
		|| state_q == ada_pkg::ST_HWM, state_q == ada_pkg::ST_TX};
	logic [1:0] stat_sent_q;
	ada_pkg::ada_event_t pend_ev_q;
	logic [9:0] pend_addr_q;
	logic pend_ten_q;
	wire evt_go = evt_x.s_load && !evt_x.s_busy;
	assign evt_x.s_data = {pend_ev_q, pend_addr_q, pend_ten_q, stat_now};
	assign evt_x.s_load = pend_ev_q != ada_pkg::EV_NONE || stat_now != stat_sent_q;
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_sent_q <= 2'b00;
			pend_ev_q <= ada_pkg::EV_NONE;
			pend_addr_q <= 10'h000;
			pend_ten_q <= 1'b0;
		end else begin
			if (evt_go) begin
				stat_sent_q <= stat_now;
				pend_ev_q <= ada_pkg::EV_NONE;
			end
			// A new event in the sending cycle takes precedence over the clear
			if (byte_done && dec_ev != ada_pkg::EV_NONE) begin
				pend_ev_q <= dec_ev;
				pend_ten_q <= hwm_ten;
				pend_addr_q <= hwm_ten ? {hwm_q[1:0], shift_q} : {3'b000, hwm_q};
			end
		end
	end

	// System side: status levels and event pulses
	logic addressed_q;
	logic tx_q;
	logic gc_reset_q;
	logic gc_load_q;
	logic hwm_q_s;
	logic hwm_ten_q;
	logic [9:0] hwm_addr_q;
	wire [1:0] rx_ev = evt_x.d_data[14:13];
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addressed_q <= 1'b0;
			tx_q <= 1'b0;
			gc_reset_q <= 1'b0;
			gc_load_q <= 1'b0;
			hwm_q_s <= 1'b0;
			hwm_ten_q <= 1'b0;
			hwm_addr_q <= 10'h000;
		end else begin
			gc_reset_q <= evt_x.d_valid && rx_ev == ada_pkg::EV_RESET;
			gc_load_q <= evt_x.d_valid && rx_ev == ada_pkg::EV_LOAD;
			hwm_q_s <= evt_x.d_valid && rx_ev == ada_pkg::EV_HWM;
			if (evt_x.d_valid) begin
				addressed_q <= evt_x.d_data[1];
				tx_q <= evt_x.d_data[0];
				if (rx_ev == ada_pkg::EV_HWM) begin
					hwm_addr_q <= evt_x.d_data[12:3];
					hwm_ten_q <= evt_x.d_data[2];
				end
			end
		end
	end
	assign addressed_o = addressed_q;
	assign transmitter_o = tx_q;
	assign gc_reset_o = gc_reset_q;
	assign gc_load_o = gc_load_q;
	assign hw_master_o = hwm_q_s;
	assign hw_master_ten_o = hwm_ten_q;
	assign hw_master_addr_o = hwm_addr_q;

	// Checks on the link domain; the broadcast reset pulse checks run on the system clock
	AST_START_REARM: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		start_w |=> state_q == ada_pkg::ST_HDR && bit_q == ada_pkg::BIT_FIRST && !ack_q)
		else $error("start did not rearm address phase");
	AST_HDR_ACK: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && header_ack |=> ack_q && state_q == ada_pkg::ST_LOW)
		else $error("matching 10-bit write header not acknowledged");
	AST_LOW_ACK: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_LOW |=> ack_q == $past(low_address_ack) && sel10_q == ack_q)
		else $error("second address byte acknowledge wrong");
	AST_READDR: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && readdress_ack |=> ack_q && sel10_q && state_q == ada_pkg::ST_TX)
		else $error("re-address did not enter transmitter role");
	AST_SEVEN_NO_TEN: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && is_ten_hdr && (!ten_l || (rw && !sel10_q)) |=> !ack_q)
		else $error("10-bit header wrongly acknowledged");
	AST_SYNC_NO_ACK: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && is_sync |=> !ack_q)
		else $error("sync byte acknowledged");
	AST_RSV_NO_ACK: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && (is_rsv || is_ext) |=> !ack_q)
		else $error("reserved address acknowledged");
	AST_GC_OFF: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_HDR && is_sync == 1'b0 && a7 == ada_pkg::GC_ADDR |=> ack_q == $past(gc_en_l))
		else $error("broadcast acknowledge disagrees with enable");
	AST_GC_DECLINE: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		byte_done && state_q == ada_pkg::ST_GC && !shift_q[0] && shift_q != ada_pkg::GC_CMD_RESET
		&& shift_q != ada_pkg::GC_CMD_LOAD |=> !ack_q && state_q == ada_pkg::ST_SKIP)
		else $error("undefined broadcast command acknowledged");
	AST_STOP_DESELECT: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
		stop_w |=> state_q == ada_pkg::ST_IDLE && !sel10_q)
		else $error("stop did not deselect");
	AST_RESET_PULSE: assert property (@(posedge clk_i) disable iff (!nrst_i)
		gc_reset_q |=> !gc_reset_q && !gc_load_q)
		else $error("broadcast reset pulse too long");
	COV_READDR: cover property (@(posedge link_clk_i) disable iff (!nrst_i) byte_done && readdress_ack);
	COV_SEVEN: cover property (@(posedge link_clk_i) disable iff (!nrst_i) byte_done && seven_ack);
	COV_GC_RESET: cover property (@(posedge clk_i) disable iff (!nrst_i) gc_reset_q);
endmodule

// [test/ada_bus_model.sv]
// Bus master model: drives the bus clock and a wired-and data line with pull-up
`timescale 1ns/1ps
module ada_bus_model (
	input wire logic clk_i,
	input wire logic slv_oe_i,
	input wire logic slv_val_i,
	output logic scl_o,
	output logic sda_o
);
	logic rel_q;
	// Released line reads high through the pull-up unless the slave pulls it low
	assign sda_o = rel_q & (~slv_oe_i | slv_val_i);
	initial begin
		rel_q = 1'b1;
		scl_o = 1'b1;
	end
	// Phase of 20 system cycles stays above 5 link cycles
	task automatic hp();
		repeat (20) @(negedge clk_i);
	endtask
	// Also serves as repeated start when entered with the clock low
	task automatic start();
		rel_q = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		rel_q = 1'b0;
		hp();
		scl_o = 1'b0;
		hp();
	endtask
	task automatic stop();
		rel_q = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		rel_q = 1'b1;
		hp();
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			rel_q = b[i];
			hp();
			scl_o = 1'b1;
			hp();
			scl_o = 1'b0;
			hp();
		end
		rel_q = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		ack = ~sda_o;
		scl_o = 1'b0;
		hp();
	endtask
endmodule

// [test/i2c_address_decoder_test.sv]
// Self-checking bench for the bus address decoder
`timescale 1ns/1ps
module i2c_address_decoder_test;
	logic clk_i, nrst_i, link_clk_i, ten_bit_i, gc_en_i, scl, sda, a;
	logic [9:0] own_addr_i, hw_master_addr_o;
	logic sda_o, sda_oe_o, addressed_o, transmitter_o, gc_reset_o, gc_load_o, hw_master_o, hw_master_ten_o;
	int mismatches, comparisons, cycles, n_rst, n_load, n_hwm;
	logic [7:0] rsv [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0b, 8'hf8, 8'hf9};
	ada_addr_decoder uut (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
		.own_addr_i(own_addr_i), .ten_bit_i(ten_bit_i), .gc_en_i(gc_en_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.addressed_o(addressed_o), .transmitter_o(transmitter_o), .gc_reset_o(gc_reset_o), .gc_load_o(gc_load_o),
		.hw_master_o(hw_master_o), .hw_master_ten_o(hw_master_ten_o), .hw_master_addr_o(hw_master_addr_o));
	ada_bus_model mdl (.clk_i(clk_i), .slv_oe_i(sda_oe_o), .slv_val_i(sda_o), .scl_o(scl), .sda_o(sda));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Link clock kept out of phase with the system clock
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #62.5 link_clk_i = ~link_clk_i;
	end
	task automatic give_verdict();
		$display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Ceiling sits well above the roughly 33300 cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (gc_reset_o === 1'b1)
			n_rst++;
		if (gc_load_o === 1'b1)
			n_load++;
		if (hw_master_o === 1'b1)
			n_hwm++;
		if (cycles == 90000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic ck(input logic [9:0] got, input logic [9:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h", $time, msg, got);
		end
	endtask
	task automatic xb(input logic [7:0] b, input logic exp, input string msg);
		mdl.send_byte(b, a);
		ck({9'h000, a}, {9'h000, exp}, msg);
	endtask
	task automatic gap();
		repeat (40) @(negedge clk_i);
	endtask
	task automatic cfg(input logic [9:0] own, input logic ten, input logic gc);
		own_addr_i = own;
		ten_bit_i = ten;
		gc_en_i = gc;
		n_rst = 0;
		n_load = 0;
		n_hwm = 0;
		repeat (100) @(negedge clk_i);
	endtask
	task automatic t_seven();
		cfg(10'h02a, 1'b0, 1'b0);
		mdl.start();
		xb(8'h54, 1'b1, "own write hdr");
		xb(8'h3c, 1'b1, "data byte");
		ck({9'h000, addressed_o}, 10'h001, "selected");
		ck({9'h000, transmitter_o}, 10'h000, "not transmitter");
		mdl.stop();
		gap();
		ck({9'h000, addressed_o}, 10'h000, "released on stop");
		mdl.start();
		xb(8'h55, 1'b1, "own read hdr");
		gap();
		ck({9'h000, transmitter_o}, 10'h001, "transmitter");
		mdl.stop();
		mdl.start();
		xb(8'h56, 1'b0, "foreign hdr");
		mdl.stop();
	endtask
	// Own address placed inside the reserved block must still never match
	task automatic t_reserved();
		cfg(10'h003, 1'b0, 1'b1);
		foreach (rsv[i]) begin
			mdl.start();
			xb(rsv[i], 1'b0, "reserved hdr");
			mdl.stop();
		end
		cfg(10'h07a, 1'b0, 1'b1);
		mdl.start();
		xb(8'hf4, 1'b0, "ten hdr in seven mode");
		mdl.stop();
		gap();
		ck({9'h000, addressed_o}, 10'h000, "never selected");
	endtask
	// Second broadcast byte 00h is never sent by this master
	task automatic t_gc(input logic ten);
		cfg(10'h02a, ten, 1'b1);
		mdl.start();
		xb(8'h00, 1'b1, "broadcast");
		xb(8'h06, 1'b1, "reset cmd");
		mdl.stop();
		mdl.start();
		xb(8'h00, 1'b1, "broadcast");
		xb(8'h04, 1'b1, "load cmd");
		mdl.stop();
		mdl.start();
		xb(8'h00, 1'b1, "broadcast");
		xb(8'h08, 1'b0, "unknown cmd");
		mdl.stop();
		gap();
		ck({8'h00, n_rst == 1, n_load == 1}, 10'h003, "cmd pulses");
		mdl.start();
		xb(8'h00, 1'b1, "broadcast");
		xb(8'h5b, 1'b1, "announce");
		xb(8'h77, 1'b1, "announce data");
		mdl.stop();
		gap();
		ck(hw_master_addr_o, 10'h02d, "master addr");
		ck({9'h000, hw_master_ten_o}, 10'h000, "master short");
		mdl.start();
		xb(8'h00, 1'b1, "broadcast");
		xb(8'hf3, 1'b1, "long announce");
		xb(8'h77, 1'b1, "low bits");
		mdl.stop();
		gap();
		ck(hw_master_addr_o, 10'h177, "long master addr");
		ck({9'h000, hw_master_ten_o}, 10'h001, "master long");
		ck({8'h00, n_hwm == 2, n_rst == 1}, 10'h003, "announce pulses");
		cfg(10'h02a, ten, 1'b0);
		mdl.start();
		xb(8'h00, 1'b0, "broadcast unwanted");
		mdl.stop();
	endtask
	task automatic t_ten();
		cfg(10'h2b5, 1'b1, 1'b1);
		mdl.start();
		xb(8'hf4, 1'b1, "ten write hdr");
		xb(8'hb5, 1'b1, "low match");
		mdl.start();
		xb(8'hf5, 1'b1, "readdress");
		gap();
		ck({8'h00, addressed_o, transmitter_o}, 10'h003, "ten transmitter");
		mdl.stop();
		gap();
		ck({9'h000, addressed_o}, 10'h000, "stop ends selection");
		mdl.start();
		xb(8'hf4, 1'b1, "ten write hdr");
		xb(8'hb4, 1'b0, "low mismatch");
		mdl.stop();
		mdl.start();
		xb(8'hf5, 1'b0, "read hdr unselected");
		mdl.stop();
		mdl.start();
		xb(8'h01, 1'b0, "sync byte");
		mdl.start();
		xb(8'hf4, 1'b1, "hdr after sync");
		xb(8'hb5, 1'b1, "low after sync");
		mdl.start();
		xb(8'h54, 1'b0, "other address");
		gap();
		ck({9'h000, addressed_o}, 10'h000, "deselected");
		mdl.stop();
	endtask
	initial begin
		nrst_i = 1'b0;
		own_addr_i = 10'h000;
		ten_bit_i = 1'b0;
		gc_en_i = 1'b0;
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		t_seven();
		t_reserved();
		t_gc(1'b0);
		t_gc(1'b1);
		t_ten();
		give_verdict();
	end
endmodule
